// [rtl/plld_defs.svh]
`ifndef PLLD_DEFS_SVH
`define PLLD_DEFS_SVH
// Contract
// - Every lock detect function except the free-running timer clock runs only while the global enable bit is set.
// - Window source zero selects the fixed short window of nominally 10 ns.
// - Window source one times the window with the digital window timer.
// - Two-bit speed field sets timer clock rate, 00 fastest, 11 slowest.
// - Divide codes 0 to 7 mean 0.5, 1, 2, 4, 8, 16, 32, 64 timer clock periods.
// - Digital window width follows both speed and divide settings.
// - Lock declared after the selected number of consecutive in-window arrivals.
// - One arrival outside the window drops lock at once and restarts counting.
// - Window opens on whichever edge comes first; only the difference matters.
// - Status register bit one always reads the current lock flag.
// - Output select code one puts the lock flag on the shared pin.
// - With bit 6 low, a serial read borrows the pin, then lock returns.
// - Timer clock is visible on the general test output when selected.
// - Large phase error raises a gain boost; threshold from a two-bit field.
// - Down and up pump gains come from two seven-bit fields.
// - Offset magnitude field plus up and down offset enables drive the pump.

`define PLLD_AW 8
`define PLLD_DW 24
`define PLLD_ADDR_LDCFG 8'h07
`define PLLD_ADDR_PUMP 8'h09
`define PLLD_ADDR_PDCTL 8'h0b
`define PLLD_ADDR_OUTSEL 8'h0f
`define PLLD_ADDR_STATUS 8'h12
`define PLLD_RST_LDCFG 24'h000000
`define PLLD_RST_PUMP 24'h000000
`define PLLD_RST_PDCTL 24'h000000
`define PLLD_RST_OUTSEL 24'h000000
`define PLLD_STAT_LOCK_BIT 1
`define PLLD_OUT_SEL_LSB 0
`define PLLD_OUT_SEL_W 5
`define PLLD_OUT_SDO_BIT 6
`define PLLD_OUT_SEL_LOCK 5'h01
`define PLLD_OUT_SEL_TIMER 5'h02
`define PLLD_CSP_LSB 7
`define PLLD_CLK_MHZ 25
`define PLLD_WIN_ANALOG_NS 10
`define PLLD_WINCNT_SHIFT 4
`define PLLD_WINCNT_W 12

`endif

// [rtl/plld_pkg.sv]
package plld_pkg;

  typedef struct packed {
    logic [11:0] rsv_hi;
    logic [1:0] speed;
    logic [2:0] div_code;
    logic src_digital;
    logic [1:0] rsv_mid;
    logic enable;
    logic [2:0] wincnt_code;
  } plld_ldcfg_t;

  typedef struct packed {
    logic rsv;
    logic offset_dn;
    logic offset_up;
    logic [6:0] offset_mag;
    logic [6:0] pump_up_gain;
    logic [6:0] pump_down_gain;
  } plld_pump_t;

  typedef enum logic [1:0] {
    CMP_IDLE = 2'b00,
    CMP_WAIT_DIV = 2'b01,
    CMP_WAIT_REF = 2'b10
  } plld_cmp_state_t;

endpackage

// [rtl/plld_window_timer.sv]
`timescale 1ns/1ps
`include "plld_defs.svh"
module plld_window_timer (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic [1:0] speed,
  input wire logic [2:0] div_code,
  input wire logic start,
  input wire logic abort,
  output logic timer_clk,
  output logic busy
);
  logic [1:0] pre_q;
  logic tick;
  logic [7:0] left_q;

  // Speed code n gives one tick every n+1 system cycles
  assign tick = (pre_q == speed);

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pre_q <= 2'h0;
    end else if (tick) begin
      pre_q <= 2'h0;
    end else begin
      pre_q <= pre_q + 2'h1;
    end
  end

  // Each tick is half a timer clock period
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      timer_clk <= 1'b0;
    end else if (tick) begin
      timer_clk <= ~timer_clk;
    end
  end

  // Divide value d means 2d half periods, so 0.5 is one tick
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      left_q <= 8'h00;
      busy <= 1'b0;
    end else if (abort) begin
      left_q <= 8'h00;
      busy <= 1'b0;
    end else if (start) begin
      // Eight bits so the largest divide of 128 half periods fits
      left_q <= 8'h01 << div_code;
      busy <= 1'b1;
    end else if (busy && tick) begin
      left_q <= left_q - 8'h01;
      busy <= (left_q != 8'h01);
    end
  end

  a_start_busy: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (start && !abort) |=> busy) else $error("timer not busy after start");
  a_tick_spacing: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (tick && speed != 2'h0) ##1 $stable(speed) |-> !tick)
    else $error("timer ticked too fast");
  a_half_divide: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (start && !abort && div_code == 3'h0) ##1 (!abort && !start) [*4] |=> !busy)
    else $error("half divide window too long");
endmodule

// [rtl/plld_top.sv]
`timescale 1ns/1ps
`include "plld_defs.svh"
module plld_top (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic [`PLLD_AW-1:0] reg_addr,
  input wire logic [`PLLD_DW-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [`PLLD_DW-1:0] reg_rdata,
  input wire logic ref_edge,
  input wire logic div_edge,
  input wire logic serial_read_active,
  input wire logic serial_read_data,
  output logic lock_or_readback_pin,
  output logic general_test_output,
  output logic cycle_slip_guard,
  output plld_pkg::plld_pump_t pump_cfg
);
  localparam int ANA_FLOOR = (`PLLD_WIN_ANALOG_NS * `PLLD_CLK_MHZ) / 1000;
  localparam int ANA_CYC = (ANA_FLOOR < 1) ? 1 : ANA_FLOOR;
  localparam int CW = `PLLD_WINCNT_W;

  plld_pkg::plld_ldcfg_t ldcfg_q;
  plld_pkg::plld_pump_t pump_q;
  logic [`PLLD_DW-1:0] pdctl_q;
  logic [`PLLD_DW-1:0] outsel_q;
  plld_pkg::plld_cmp_state_t state_q;
  plld_pkg::plld_cmp_state_t state_d;
  logic [CW-1:0] wins_q;
  logic lock_q;
  logic [3:0] ana_q;
  logic [3:0] err_q;
  logic hit;
  logic miss;
  logic start;
  logic win_open;
  logic cfg_chg;
  logic tmr_clk;
  logic tmr_busy;
  logic [`PLLD_OUT_SEL_W-1:0] out_sel;
  logic [2:0] new_div;
  logic [1:0] new_speed;
  logic new_src;

  function automatic logic [CW-1:0] wincnt_target(input logic [2:0] code);
    // Four-bit shift amount so codes 4 to 7 do not wrap
    wincnt_target = CW'(16'h0001 << (4'(code) + 4'(`PLLD_WINCNT_SHIFT)));
  endfunction

  function automatic logic addr_is(input logic [`PLLD_AW-1:0] a, input logic [`PLLD_AW-1:0] b);
    addr_is = (a == b);
  endfunction

  assign out_sel = outsel_q[`PLLD_OUT_SEL_LSB +: `PLLD_OUT_SEL_W];
  assign new_div = reg_wdata[9:7];
  assign new_speed = reg_wdata[11:10];
  assign new_src = reg_wdata[6];

  // Any change to window source, divide or speed invalidates the running count
  assign cfg_chg = reg_wr && addr_is(reg_addr, `PLLD_ADDR_LDCFG)
                   && ({new_speed, new_div, new_src}
                       != {ldcfg_q.speed, ldcfg_q.div_code, ldcfg_q.src_digital});

  // Register writes
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ldcfg_q <= `PLLD_RST_LDCFG;
      pump_q <= `PLLD_RST_PUMP;
      pdctl_q <= `PLLD_RST_PDCTL;
      outsel_q <= `PLLD_RST_OUTSEL;
    end else if (reg_wr) begin
      if (addr_is(reg_addr, `PLLD_ADDR_LDCFG)) begin
        ldcfg_q <= reg_wdata;
      end
      if (addr_is(reg_addr, `PLLD_ADDR_PUMP)) begin
        pump_q <= reg_wdata;
      end
      if (addr_is(reg_addr, `PLLD_ADDR_PDCTL)) begin
        pdctl_q <= reg_wdata;
      end
      if (addr_is(reg_addr, `PLLD_ADDR_OUTSEL)) begin
        outsel_q <= reg_wdata;
      end
    end
  end

  assign pump_cfg = pump_q;

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= '0;
    end else if (!reg_rd) begin
      reg_rdata <= '0;
    end else begin
      case (reg_addr)
        `PLLD_ADDR_LDCFG: reg_rdata <= ldcfg_q;
        `PLLD_ADDR_PUMP: reg_rdata <= pump_q;
        `PLLD_ADDR_PDCTL: reg_rdata <= pdctl_q;
        `PLLD_ADDR_OUTSEL: reg_rdata <= outsel_q;
        `PLLD_ADDR_STATUS: begin
          reg_rdata <= '0;
          reg_rdata[`PLLD_STAT_LOCK_BIT] <= lock_q;
        end
        default: reg_rdata <= '0;
      endcase
    end
  end

  plld_window_timer u_timer (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .speed(ldcfg_q.speed),
    .div_code(ldcfg_q.div_code),
    .start(start && ldcfg_q.src_digital),
    .abort(cfg_chg || !ldcfg_q.enable),
    .timer_clk(tmr_clk),
    .busy(tmr_busy)
  );

  // Fixed window is shorter than a cycle, so it rounds up to one whole cycle
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ana_q <= 4'h0;
    end else if (start && !ldcfg_q.src_digital) begin
      ana_q <= 4'(ANA_CYC);
    end else if (ana_q != 4'h0) begin
      ana_q <= ana_q - 4'h1;
    end
  end

  assign win_open = ldcfg_q.src_digital ? tmr_busy : (ana_q != 4'h0);

  // Comparison sequencing
  always_comb begin
    state_d = state_q;
    hit = 1'b0;
    miss = 1'b0;
    start = 1'b0;
    case (state_q)
      plld_pkg::CMP_IDLE: begin
        if (ref_edge && div_edge) begin
          hit = 1'b1;
        end else if (ref_edge) begin
          start = 1'b1;
          state_d = plld_pkg::CMP_WAIT_DIV;
        end else if (div_edge) begin
          start = 1'b1;
          state_d = plld_pkg::CMP_WAIT_REF;
        end
      end
      plld_pkg::CMP_WAIT_DIV: begin
        if (div_edge && win_open && !ref_edge) begin
          hit = 1'b1;
          state_d = plld_pkg::CMP_IDLE;
        end else if (!win_open || ref_edge || div_edge) begin
          miss = 1'b1;
          state_d = plld_pkg::CMP_IDLE;
        end
      end
      plld_pkg::CMP_WAIT_REF: begin
        if (ref_edge && win_open && !div_edge) begin
          hit = 1'b1;
          state_d = plld_pkg::CMP_IDLE;
        end else if (!win_open || ref_edge || div_edge) begin
          miss = 1'b1;
          state_d = plld_pkg::CMP_IDLE;
        end
      end
      default: begin
        state_d = plld_pkg::CMP_IDLE;
      end
    endcase
    if (!ldcfg_q.enable || cfg_chg) begin
      state_d = plld_pkg::CMP_IDLE;
      hit = 1'b0;
      miss = 1'b0;
      start = 1'b0;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= plld_pkg::CMP_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // Consecutive in-window count and lock flag
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      wins_q <= '0;
      lock_q <= 1'b0;
    end else if (!ldcfg_q.enable || cfg_chg) begin
      wins_q <= '0;
      lock_q <= 1'b0;
    end else if (miss) begin
      wins_q <= '0;
      lock_q <= 1'b0;
    end else if (hit) begin
      if (wins_q + CW'(1) >= wincnt_target(ldcfg_q.wincnt_code)) begin
        lock_q <= 1'b1;
      end else begin
        wins_q <= wins_q + CW'(1);
      end
    end
  end

  // Phase error age; the guard only widens gain, it never touches lock
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      err_q <= 4'h0;
    end else if (state_q == plld_pkg::CMP_IDLE || state_d == plld_pkg::CMP_IDLE) begin
      err_q <= 4'h0;
    end else if (err_q != 4'hf) begin
      err_q <= err_q + 4'h1;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cycle_slip_guard <= 1'b0;
    end else begin
      cycle_slip_guard <= ldcfg_q.enable && (state_q != plld_pkg::CMP_IDLE)
                          && (err_q > {2'h0, pdctl_q[`PLLD_CSP_LSB +: 2]});
    end
  end

  // Shared pin and test output
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      lock_or_readback_pin <= 1'b0;
    end else if (serial_read_active && !outsel_q[`PLLD_OUT_SDO_BIT]) begin
      lock_or_readback_pin <= serial_read_data;
    end else if (out_sel == `PLLD_OUT_SEL_LOCK) begin
      lock_or_readback_pin <= lock_q;
    end else begin
      lock_or_readback_pin <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      general_test_output <= 1'b0;
    end else begin
      general_test_output <= (out_sel == `PLLD_OUT_SEL_TIMER) && tmr_clk;
    end
  end

  sequence s_fixed_open;
    start && !ldcfg_q.src_digital;
  endsequence

  sequence s_quiet_cfg;
    ldcfg_q.enable && !cfg_chg;
  endsequence

  a_lock_needs_en: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !ldcfg_q.enable |=> !lock_q) else $error("lock held while disabled");
  a_fixed_window: assert property (@(posedge sys_clk) disable iff (!rst_n)
    s_fixed_open ##1 (s_quiet_cfg && !hit && !miss) ##1 s_quiet_cfg |-> miss)
    else $error("fixed window not closed after one cycle");
  a_lock_on_count: assert property (@(posedge sys_clk) disable iff (!rst_n)
    $rose(lock_q) |-> $past(hit)
      && ($past(wins_q) + CW'(1) >= $past(wincnt_target(ldcfg_q.wincnt_code))))
    else $error("lock without full count");
  a_miss_drops: assert property (@(posedge sys_clk) disable iff (!rst_n)
    miss |=> !lock_q && wins_q == '0) else $error("miss kept lock");
  a_both_edges_hit: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (state_q == plld_pkg::CMP_IDLE && ref_edge && div_edge && ldcfg_q.enable && !cfg_chg)
      |-> hit) else $error("coincident edges not a hit");
  a_status_read: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (reg_rd && reg_addr == `PLLD_ADDR_STATUS) |=>
      reg_rdata[`PLLD_STAT_LOCK_BIT] == $past(lock_q)) else $error("status lock mismatch");
  a_pin_shows_lock: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (out_sel == `PLLD_OUT_SEL_LOCK && !serial_read_active) |=>
      lock_or_readback_pin == $past(lock_q)) else $error("pin not lock flag");
  a_pin_readback: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (serial_read_active && !outsel_q[`PLLD_OUT_SDO_BIT]) |=>
      lock_or_readback_pin == $past(serial_read_data)) else $error("pin not readback");
  a_cfg_clears: assert property (@(posedge sys_clk) disable iff (!rst_n)
    cfg_chg |=> !lock_q && wins_q == '0 && state_q == plld_pkg::CMP_IDLE)
    else $error("setting change kept lock");
endmodule

// [sim/plld_edge_src.sv]
`timescale 1ns/1ps
module plld_edge_src (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic fire,
  input wire logic swap,
  input wire logic [9:0] off,
  output logic ref_edge,
  output logic div_edge
);
  logic [9:0] t_q;
  logic act_q;
  // One comparison per fire; the bench picks the offset against the window
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      t_q <= '0;
      act_q <= 1'b0;
      ref_edge <= 1'b0;
      div_edge <= 1'b0;
    end else if (fire) begin
      t_q <= 10'h001;
      act_q <= (off != 10'h000);
      ref_edge <= !swap || (off == 10'h000);
      div_edge <= swap || (off == 10'h000);
    end else if (act_q) begin
      ref_edge <= swap && (t_q == off);
      div_edge <= !swap && (t_q == off);
      act_q <= (t_q != off);
      t_q <= t_q + 10'h001;
    end else begin
      ref_edge <= 1'b0;
      div_edge <= 1'b0;
    end
  end
endmodule

// [sim/tb_top.sv]
`timescale 1ns/1ps
module tb_top;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [23:0] reg_wdata = 24'h000000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic sra = 1'b0;
  logic srd = 1'b0;
  logic fire = 1'b0;
  logic swap = 1'b0;
  logic [9:0] off = 10'h000;
  logic [23:0] reg_rdata;
  logic ref_edge, div_edge, pin, gto, csg;
  logic slip_seen = 1'b0;
  int tgl = 0;
  plld_pkg::plld_pump_t pump_cfg;
  int miscompares = 0;
  int checks_done = 0;
  always #20 sys_clk = ~sys_clk;
  plld_top u_dut (.sys_clk(sys_clk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .ref_edge(ref_edge), .div_edge(div_edge), .serial_read_active(sra),
    .serial_read_data(srd), .lock_or_readback_pin(pin), .general_test_output(gto),
    .cycle_slip_guard(csg), .pump_cfg(pump_cfg));
  plld_edge_src u_src (.sys_clk(sys_clk), .rst_n(rst_n), .fire(fire), .swap(swap),
    .off(off), .ref_edge(ref_edge), .div_edge(div_edge));
  always @(posedge sys_clk) if (csg === 1'b1) slip_seen <= 1'b1;
  always @(gto) tgl++;
  task chk(string n, logic [23:0] e, logic [23:0] g);
    checks_done++;
    if (g !== e) begin
      miscompares++;
      $display("BAD %s exp %h got %h", n, e, g);
    end
  endtask
  task wr(logic [7:0] a, logic [23:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    @(posedge sys_clk);
  endtask
  task rd(logic [7:0] a, output logic [23:0] d);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    @(posedge sys_clk);
    d = reg_rdata;
  endtask
  task lk(logic e);
    logic [23:0] d;
    rd(8'h12, d);
    chk("lock", 24'(e), 24'(d[1]));
  endtask
  task cmp(int o, logic s = 1'b0);
    off <= 10'(o);
    swap <= s;
    fire <= 1'b1;
    @(posedge sys_clk);
    fire <= 1'b0;
    repeat (o + 4) @(posedge sys_clk);
  endtask
  // Random arrival order keeps both first-edge cases busy
  task hits(int n, int o);
    repeat (n) cmp(o, 1'($urandom_range(1, 0)));
  endtask
  function logic [23:0] ldcfg(logic en, logic src, logic [1:0] sp, logic [2:0] dv);
    plld_pkg::plld_ldcfg_t c;
    c = '0;
    c.enable = en;
    c.src_digital = src;
    c.speed = sp;
    c.div_code = dv;
    return c;
  endfunction
  // Longest window in cycles: 2^div ticks, one tick per speed+1 cycles
  // Free-running tick phase can shorten it by up to speed cycles
  function int win(int sp, int dv);
    return (sp + 1) << dv;
  endfunction
  task done(string n);
    $display("test %s done", n);
  endtask
  task finish_test;
    $display("checks %0d miscompares %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    logic [23:0] d, v;
    logic [7:0] al [5];
    int w, n;
    al = '{8'h07, 8'h09, 8'h0b, 8'h0f, 8'h33};
    void'($urandom(32'hd1ef));
    repeat (3) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(posedge sys_clk);
    foreach (al[i]) begin
      rd(al[i], d);
      chk("reset", 24'h000000, d);
    end
    lk(1'b0);
    chk("pump", 24'h000000, pump_cfg);
    done("reset");
    v = 24'($urandom);
    wr(8'h09, v);
    rd(8'h09, d);
    chk("r09", v, d);
    chk("pump", v, pump_cfg);
    v = 24'($urandom);
    wr(8'h0b, v);
    rd(8'h0b, d);
    chk("r0b", v, d);
    wr(8'h12, 24'hffffff);
    lk(1'b0);
    wr(8'h33, v);
    rd(8'h33, d);
    chk("unmapped", 24'h000000, d);
    done("regs");
    wr(8'h0f, 24'h000001);
    // Fixed window with tiny offsets only
    wr(8'h07, ldcfg(1'b1, 1'b0, 2'h0, 3'h0));
    hits(15, 1);
    lk(1'b0);
    cmp(0);
    lk(1'b1);
    chk("pin", 24'h000001, pin);
    cmp(2);
    lk(1'b0);
    chk("pin", 24'h000000, pin);
    hits(15, 0);
    lk(1'b0);
    cmp(1, 1'b1);
    lk(1'b1);
    done("fixed");
    repeat (4) begin
      v = 24'($urandom);
      sra <= 1'b1;
      srd <= v[0];
      repeat (3) @(posedge sys_clk);
      chk("readback", 24'(v[0]), pin);
      sra <= 1'b0;
      repeat (3) @(posedge sys_clk);
      chk("pin", 24'h000001, pin);
    end
    wr(8'h0f, 24'h000041);
    sra <= 1'b1;
    srd <= 1'b0;
    repeat (3) @(posedge sys_clk);
    chk("pin kept", 24'h000001, pin);
    sra <= 1'b0;
    done("pin");
    wr(8'h07, ldcfg(1'b1, 1'b0, 2'h1, 3'h0));
    lk(1'b0);
    hits(16, 0);
    lk(1'b1);
    wr(8'h07, ldcfg(1'b0, 1'b0, 2'h1, 3'h0));
    lk(1'b0);
    hits(16, 0);
    lk(1'b0);
    done("enable");
    for (int sp = 0; sp < 4; sp++) begin
      for (int dv = 0; dv < 4; dv++) begin
        w = win(sp, dv);
        wr(8'h07, ldcfg(1'b1, 1'b1, 2'(sp), 3'(dv)));
        hits(16, (w - sp + 1) / 2);
        lk(1'b1);
        cmp(2 * w + 2);
        lk(1'b0);
      end
    end
    done("digital");
    wr(8'h0f, 24'h000002);
    wr(8'h07, ldcfg(1'b1, 1'b1, 2'h0, 3'h3));
    tgl = 0;
    cmp(20);
    chk("timer out", 24'h000001, 24'(tgl > 1));
    wr(8'h0f, 24'h000001);
    // Let the last output update settle before counting toggles
    @(posedge sys_clk);
    tgl = 0;
    cmp(20);
    chk("timer off", 24'h000000, 24'(tgl));
    done("timer");
    wr(8'h07, ldcfg(1'b1, 1'b1, 2'h3, 3'h7));
    repeat (4) begin
      n = $urandom_range(3, 0);
      wr(8'h0b, 24'(n) << 7);
      slip_seen = 1'b0;
      cmp(0);
      chk("guard quiet", 24'h000000, 24'(slip_seen));
      slip_seen = 1'b0;
      cmp(20);
      chk("guard", 24'h000001, 24'(slip_seen));
    end
    done("slip");
    finish_test;
  end
  initial begin
    repeat (100000) @(posedge sys_clk);
    miscompares++;
    finish_test;
  end
endmodule
